// File: include/p9gp_cfg.svh
// port9 gpio pin mux: register offsets, reset values and bit positions
// assumes inclusion by bare name from the design module
`ifndef P9GP_CFG_SVH
`define P9GP_CFG_SVH
`define P9GP_OFF_DIR        16'hffc0
`define P9GP_OFF_DATA       16'hffc1
`define P9GP_OFF_MODE       16'hffc4
`define P9GP_DIR_RST_EXP    8'h40
`define P9GP_DIR_RST_SC     8'h00
`define P9GP_DATA_RST       8'h00
`define P9GP_DIR_RD_VAL     32'hffff_ffff
`define P9GP_BIT_CLK        6
`define P9GP_BIT_WAIT       7
`define P9GP_BIT_AS         5
`define P9GP_BIT_WR         4
`define P9GP_BIT_RD         3
`define P9GP_BIT_I0         2
`define P9GP_BIT_I1         1
`define P9GP_BIT_I2         0
`endif

// File: include/p9gp_pkg.sv
// port9 gpio pin mux: shared types
// assumes the cfg header sits on the include path
package p9gp_pkg;
   // one packed word of all block state
   typedef struct packed {
      logic [7:0] dir;      // direction latch
      logic [7:0] data;     // output data latch
      logic [7:0] sync1;    // first pin synchroniser stage
      logic [7:0] sync2;    // second pin synchroniser stage
      logic [31:0] prdata;  // registered read data
   } p9gp_state_t;
endpackage : p9gp_pkg

// File: src/p9gp_port.sv
// port9 gpio pin mux: eight pins, direction/data registers on apb,
// routing of bus strobes, clock, wait, ext interrupts, converter trigger,
// host inputs and i2c data line.
// assumes peripheral signals are on clk_sys_i; pins are asynchronous.
`timescale 1ns/1ps
`include "p9gp_cfg.svh"
module p9gp_port
   import p9gp_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        rstn_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [15:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // mode and standby
   input  wire logic        mode_expanded_i,
   input  wire logic        hw_standby_i,
   input  wire logic        slave_mode_i,
   // control bits owned by other blocks
   input  wire logic        slave_alt_select_i,
   input  wire logic        iic_bus_enable_i,
   input  wire logic        wait_enable_i,
   input  wire logic        ext_int0_enable_i,
   input  wire logic        ext_int1_enable_i,
   input  wire logic        ext_int2_enable_i,
   input  wire logic        conv_trigger_enable_i,
   // peripheral outputs
   input  wire logic        sys_clk_out_i,
   input  wire logic        address_strobe_i,
   input  wire logic        write_strobe_i,
   input  wire logic        read_strobe_i,
   input  wire logic        iic_sda_oe_i,
   // peripheral inputs (synchronised pin levels)
   output logic             wait_in_o,
   output logic             iic_sda_in_o,
   output logic             ext_int0_o,
   output logic             ext_int1_o,
   output logic             ext_int2_o,
   output logic             conv_ext_trigger_o,
   output logic             host_io_write_o,
   output logic             host_chip_select2_o,
   // pins
   input  wire logic [7:0]  pin_i,
   output logic      [7:0]  pin_o,
   output logic      [7:0]  pin_oe_o
);

   p9gp_state_t st_reg;   // registered state
   p9gp_state_t st_next;  // next state
   logic        wr_en;    // apb write access phase
   logic        rd_en;    // apb read setup phase
   logic [7:0]  port_rd;  // port read value
   logic        host_pin; // slave alt select active on pins 1,0
   logic [7:0]  dir_wr;   // direction after write masking

   // decode the apb access; slave answers with no wait states
   // read data is loaded at the setup edge so that it already stands, from a flip-flop,
   // at the edge where the master samples pready high; a pin that moves during the
   // access phase is therefore not seen by that read, which software cannot tell apart
   assign wr_en     = psel_i & penable_i & pwrite_i;
   assign rd_en     = psel_i & ~penable_i & ~pwrite_i;
   assign pready_o  = 1'b1;
   assign prdata_o  = st_reg.prdata;
   assign pslverr_o = psel_i & penable_i & (paddr_i != `P9GP_OFF_DIR) & (paddr_i != `P9GP_OFF_DATA);

   // host pin selection: alt select is consulted for pins 1 and 0 only
   assign host_pin = slave_mode_i & slave_alt_select_i;

   // per-bit port read: output bits from latch, inputs from pin, bit 6 always pin
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         port_rd[i] = st_reg.dir[i] ? st_reg.data[i] : st_reg.sync2[i];
      end
      port_rd[`P9GP_BIT_CLK] = st_reg.sync2[`P9GP_BIT_CLK];
   end

   // direction write with pin 6 held in expanded modes
   always_comb begin
      dir_wr = pwdata_i[7:0];
      if (mode_expanded_i) begin
         dir_wr[`P9GP_BIT_CLK] = 1'b1;
      end
   end

   // next-state logic for all registers
   always_comb begin
      st_next       = st_reg;
      st_next.sync1 = pin_i;
      st_next.sync2 = st_reg.sync1;
      if (hw_standby_i) begin
         // hardware standby reinitialises; software standby is simply not visible here
         st_next.dir  = mode_expanded_i ? `P9GP_DIR_RST_EXP : `P9GP_DIR_RST_SC;
         st_next.data = `P9GP_DATA_RST;
      end else if (wr_en && paddr_i == `P9GP_OFF_DIR) begin
         st_next.dir = dir_wr;
      end else if (wr_en && paddr_i == `P9GP_OFF_DATA) begin
         st_next.data = pwdata_i[7:0];
         st_next.data[`P9GP_BIT_CLK] = 1'b0;
      end
      if (mode_expanded_i) begin
         st_next.dir[`P9GP_BIT_CLK] = 1'b1;
      end
      if (rd_en) begin
         if (paddr_i == `P9GP_OFF_DIR) begin
            st_next.prdata = `P9GP_DIR_RD_VAL;
         end else if (paddr_i == `P9GP_OFF_DATA) begin
            st_next.prdata = {24'h00_0000, port_rd};
         end else begin
            st_next.prdata = 32'h0000_0000;
         end
      end
   end

   // state register; strap mode is re-applied by the comb path after release
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // pin drive: gpio by direction unless a peripheral owns the pin
   always_comb begin
      pin_o    = st_reg.data;
      pin_oe_o = st_reg.dir;
      // pin 7
      if (mode_expanded_i && wait_enable_i) begin
         pin_oe_o[`P9GP_BIT_WAIT] = 1'b0;
      end else if (iic_bus_enable_i) begin
         pin_o[`P9GP_BIT_WAIT]    = 1'b0;
         pin_oe_o[`P9GP_BIT_WAIT] = iic_sda_oe_i;
      end
      // pin 6 clock out
      pin_o[`P9GP_BIT_CLK] = sys_clk_out_i;
      pin_oe_o[`P9GP_BIT_CLK] = mode_expanded_i | st_reg.dir[`P9GP_BIT_CLK];
      // pins 5..3 strobes
      if (mode_expanded_i) begin
         pin_o[`P9GP_BIT_AS]    = address_strobe_i;
         pin_o[`P9GP_BIT_WR]    = write_strobe_i;
         pin_o[`P9GP_BIT_RD]    = read_strobe_i;
         pin_oe_o[`P9GP_BIT_AS] = 1'b1;
         pin_oe_o[`P9GP_BIT_WR] = 1'b1;
         pin_oe_o[`P9GP_BIT_RD] = 1'b1;
      end
      // pins 1,0 become host inputs
      if (host_pin) begin
         pin_oe_o[`P9GP_BIT_I1] = 1'b0;
         pin_oe_o[`P9GP_BIT_I2] = 1'b0;
      end
   end

   // peripheral inputs from synchronised pins, gated by enables except iic_sda_in_o, which is ungated
   always_comb begin
      wait_in_o           = mode_expanded_i & wait_enable_i & st_reg.sync2[`P9GP_BIT_WAIT];
      iic_sda_in_o        = st_reg.sync2[`P9GP_BIT_WAIT];
      ext_int0_o          = ext_int0_enable_i & st_reg.sync2[`P9GP_BIT_I0];
      ext_int1_o          = ext_int1_enable_i & st_reg.sync2[`P9GP_BIT_I1];
      ext_int2_o          = ext_int2_enable_i & st_reg.sync2[`P9GP_BIT_I2];
      conv_ext_trigger_o  = conv_trigger_enable_i & ~host_pin & st_reg.sync2[`P9GP_BIT_I2];
      host_io_write_o     = host_pin & st_reg.sync2[`P9GP_BIT_I1];
      host_chip_select2_o = host_pin & st_reg.sync2[`P9GP_BIT_I2];
   end

endmodule : p9gp_port

// File: testbench/p9gp_board.sv
// board model: resolves each pad from the device and board drivers
// assumes the bench gives a board level for every pad
`timescale 1ns/1ps
module p9gp_board (
   input  wire logic [7:0] pin_o, pin_oe_o, board_drv,  // device level, enables, board level
   output logic      [7:0] pin_i
);
   assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & board_drv);  // a driven pad shows the device
endmodule : p9gp_board

// File: testbench/p9gp_port_monitor.sv
// checker: pin routing and register effects of the port9 mux
// assumes a bind by name onto p9gp_port
`timescale 1ns/1ps
module p9gp_monitor (
   input wire logic        clk_sys_i, rstn_i, psel_i, penable_i, pwrite_i, mode_expanded_i, wait_enable_i,
   input wire logic        ext_int0_enable_i, ext_int0_o, sys_clk_out_i, address_strobe_i, write_strobe_i,
   input wire logic        read_strobe_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i, prdata_o,
   input wire logic [7:0]  pin_i, pin_o, pin_oe_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   wire dir = psel_i && penable_i && paddr_i == 16'hffc0;  // taken edge on direction
   wire dat = psel_i && penable_i && pwrite_i && paddr_i == 16'hffc1;  // latch write
   a_strobe_route: assert property (mode_expanded_i |-> pin_oe_o[5:3] == 3'h7 &&
      pin_o[5:3] == {address_strobe_i, write_strobe_i, read_strobe_i}) else $error("strobes");
   a_clk_route: assert property (mode_expanded_i |-> pin_oe_o[6] && pin_o[6] == sys_clk_out_i) else $error("clk");
   a_clk_dir: assert property (!mode_expanded_i && dir && pwrite_i |=> pin_oe_o[6] == $past(pwdata_i[6]))
      else $error("clk dir");
   a_dir_ones: assert property (dir && !pwrite_i |=> prdata_o == 32'hffff_ffff) else $error("dir read");
   a_wait_in: assert property (mode_expanded_i && wait_enable_i |-> !pin_oe_o[7]) else $error("wait");
   a_dir_drive: assert property (dir && pwrite_i |=> pin_oe_o[2] == $past(pwdata_i[2])) else $error("dir");
   a_latch_out: assert property (dat |=> !pin_oe_o[2] || pin_o[2] == $past(pwdata_i[2])) else $error("latch");
   a_int0_level: assert property (ext_int0_enable_i && $past(rstn_i, 2) |-> ext_int0_o == $past(pin_i[2], 2))
      else $error("int0");
endmodule : p9gp_monitor
bind p9gp_port p9gp_monitor u_p9gp_monitor (.*);

// File: testbench/test_port9_gpio_pin_mux.sv
// bench: register access, pin routing and mode cases of the port9 mux
// assumes p9gp_board resolves the pads
`timescale 1ns/1ps
module test_port9_gpio_pin_mux;
   logic        clk_sys_i = '0, rstn_i = '0, psel_i = '0, penable_i = '0, pwrite_i = '0, hw_standby_i = '0, e;
   logic        mode_expanded_i = '0, slave_mode_i = '0, slave_alt_select_i = '0, iic_bus_enable_i = '0;
   logic        wait_enable_i = '0, ext_int0_enable_i = '1, ext_int1_enable_i = '1, ext_int2_enable_i = '1;
   logic        conv_trigger_enable_i = '1, sys_clk_out_i = '0, address_strobe_i = '0, write_strobe_i = '1;
   logic        read_strobe_i = '0, iic_sda_oe_i = '0, pready_o, pslverr_o, wait_in_o, iic_sda_in_o, ext_int0_o;
   logic        ext_int1_o, ext_int2_o, conv_ext_trigger_o, host_io_write_o, host_chip_select2_o;
   logic [15:0] paddr_i = '0;
   logic [31:0] pwdata_i = '0, prdata_o, r;
   logic [7:0]  pin_i, pin_o, pin_oe_o, board_drv = '0;
   int          mismatches = 0, n_tests = 0;
   // rows: direction, latch, board level, expected read
   logic [31:0] rows [3] = '{32'hffa5_00a5, 32'h00ff_3c3c, 32'h0f5a_c3ca};
   p9gp_port  u_p9gp_port (.*);
   p9gp_board u_p9gp_board (.*);
   always #4 clk_sys_i = ~clk_sys_i;  // 125 MHz
   task automatic chk(input string nm, input logic [31:0] x, g);
      n_tests++;
      if (g !== x) mismatches++;
      if (g !== x) $display("[ERR] %s exp %h got %h", nm, x, g);
   endtask : chk
   // request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk_sys_i);
      {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'h1, w, a, d};
      @(posedge clk_sys_i);
      penable_i <= 1'h1;
      @(posedge clk_sys_i);
      while (pready_o !== 1'h1 && n++ < 50) @(posedge clk_sys_i);
      e = pslverr_o;
      {psel_i, penable_i} <= 2'h0;
      r = prdata_o;  // read data stands through the access phase
   endtask : apb
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : summarize
   initial begin
      #100000 mismatches++;
      summarize();
   end
   initial begin
      repeat (8) @(posedge clk_sys_i);
      rstn_i <= 1'h1;
      @(posedge clk_sys_i);
      chk("oe", 8'h00, pin_oe_o);
      apb(0, 16'hffc0, 0);
      chk("dir", 32'hffff_ffff, r);
      foreach (rows[i]) begin
         board_drv <= rows[i][15:8];
         apb(1, 16'hffc0, rows[i][31:24]);
         apb(1, 16'hffc1, rows[i][23:16]);
         @(posedge clk_sys_i);  // let the latch write settle before looking at the pins
         chk("oe", rows[i][31:24], pin_oe_o);
         chk("out", rows[i][23:16] & rows[i][31:24] & 8'hbf, pin_o & rows[i][31:24]);
         apb(0, 16'hffc1, 0);
         chk("rd", rows[i][7:0], r);
      end
      apb(0, 16'hffc4, 0);
      chk("err", 1'h1, e);
      hw_standby_i <= 1'h1;
      @(posedge clk_sys_i);
      hw_standby_i <= 1'h0;
      apb(1, 16'hffc0, 8'hff);
      @(posedge clk_sys_i);
      chk("hws", 8'h00, pin_o);
      {slave_mode_i, slave_alt_select_i, board_drv} <= 10'h301;
      repeat (3) @(posedge clk_sys_i);
      chk("alt", 9'h1fc, {host_chip_select2_o, pin_oe_o});
      {slave_mode_i, slave_alt_select_i, mode_expanded_i, wait_enable_i, rstn_i} <= 5'h0e;
      repeat (2) @(posedge clk_sys_i);
      rstn_i <= 1'h1;
      @(posedge clk_sys_i);
      chk("oe", 8'h78, pin_oe_o);
      apb(1, 16'hffc0, 8'h80);
      @(posedge clk_sys_i);
      chk("oe", 8'h78, pin_oe_o);
      summarize();
   end
endmodule : test_port9_gpio_pin_mux
